// ---- eeprom_ecc_core.sv ----
// Purpose: spi eeprom core with power-on reset state, 4-byte ecc groups, delivery state
// Assumes: spi mode 0, pins asynchronous to i_sys_clk and slow against it
// Notes:   memory content is simulation-level storage; stored bits may be flipped by o_ tests
`timescale 1ns/1ns
// Function
// (R1) below reset threshold every serial instruction is ignored
// (R2) after threshold: standby, deselected, no hold condition
// (R3) power-on reset clears the write enable latch
// (R4) power-on reset clears write in progress
// (R5) protect and status write disable bits keep stored values through reset
// (R6) master keeps device deselected and idle during power-down
// (R7) master selects only one device at a time
// (R8) data output released to high impedance while deselected
// (R9) check bits computed over aligned groups of four bytes
// (R10) single wrong bit in a group is corrected on read
// (R11) byte write rewrites whole group with regenerated check bits
// (R12) correction adds no bytes, status or timing to transactions
// (R13) factory state array bytes read all ones
// (R14) factory state protect and status write disable bits are zero
// (R15) factory state id page first three bytes hold identification code
// (R16) power-on reset modelled as asynchronous reset of volatile state
module eeprom_ecc_core (
    // clock and power-on reset
    input  wire logic                        i_sys_clk,
    input  wire logic                        i_nrst,
    // supply detector: high when supply is above reset_threshold_voltage
    input  wire logic                        i_supply_ok,
    // spi pins
    input  wire eeprom_ecc_pkg::spi_in_type  i_spi,
    input  wire logic                        i_hold_n,
    output logic                             o_miso,
    output logic                             o_miso_oe,
    // state
    output logic                             o_write_in_progress,
    output logic                             o_write_enable_latch,
    output eeprom_ecc_pkg::nv_status_type    o_nv_status,
    output logic                             o_ecc_corrected
);
    // storage: data and per-group check bits, plus id page and nv status
    logic [31:0]                        data_mem [eeprom_ecc_pkg::NUM_GROUPS];
    logic [eeprom_ecc_pkg::CHK_W-1:0]   chk_mem  [eeprom_ecc_pkg::NUM_GROUPS];
    logic [7:0]                         id_mem   [eeprom_ecc_pkg::ID_BYTES];
    eeprom_ecc_pkg::nv_status_type      nv_reg;

    // hamming syndrome over 32 data bits; positions skip powers of two
    function automatic logic [5:0] ham(input logic [31:0] d);
        logic [5:0] s;
        int         p;
        int         k;
        s = '0;
        p = 1;
        for (k = 0; k < 32; k++) begin
            p = p + 1;
            while ((p & (p - 1)) == 0) p = p + 1;
            s = s ^ 6'(p);
            if (!d[k]) s = s ^ 6'(p);
        end
        return s;
    endfunction : ham

    // bit index of data position matching a syndrome, 32 when none
    function automatic logic [5:0] bit_of(input logic [5:0] syn);
        int         p;
        int         k;
        logic [5:0] r;
        r = 6'h20;
        p = 1;
        for (k = 0; k < 32; k++) begin
            p = p + 1;
            while ((p & (p - 1)) == 0) p = p + 1;
            if (6'(p) == syn) r = 6'(k);
        end
        return r;
    endfunction : bit_of

    // factory delivery state of the non-volatile content
    initial begin
        // (R13) erased array
        for (int g = 0; g < eeprom_ecc_pkg::NUM_GROUPS; g++) begin
            data_mem[g] = {4{eeprom_ecc_pkg::ERASED_BYTE}};
            chk_mem[g]  = ham({4{eeprom_ecc_pkg::ERASED_BYTE}});
        end
        // (R15) identification code
        for (int i = 0; i < eeprom_ecc_pkg::ID_BYTES; i++)
            id_mem[i] = 8'h00;
        id_mem[0] = eeprom_ecc_pkg::ID_CODE[23:16];
        id_mem[1] = eeprom_ecc_pkg::ID_CODE[15:8];
        id_mem[2] = eeprom_ecc_pkg::ID_CODE[7:0];
        // (R14) unprotected
        nv_reg = '0;
    end

    // two-flop synchronisers on the pins
    logic [4:0] sync1_reg;
    logic [4:0] sync2_reg;
    logic       sck_d_reg;
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sync1_reg <= 5'h12;    // deselected, clock low, no hold, supply not yet seen
            sync2_reg <= 5'h12;
            sck_d_reg <= 1'b0;
        end else begin
            sync1_reg <= {i_spi.cs_n, i_spi.sck, i_spi.mosi, i_hold_n, i_supply_ok};
            sync2_reg <= sync1_reg;
            sck_d_reg <= sync2_reg[3];
        end
    end

    // (R1) pins qualified by supply state
    wire cs_n_s   = sync2_reg[4] | ~sync2_reg[0];
    wire sck_s    = sync2_reg[3];
    wire mosi_s   = sync2_reg[2];
    wire hold_s   = ~sync2_reg[1];
    wire sck_rise = sck_s & ~sck_d_reg & ~cs_n_s & ~hold_s;
    wire sck_fall = ~sck_s & sck_d_reg & ~cs_n_s & ~hold_s;

    typedef enum logic [2:0] {ST_CMD, ST_ADDR, ST_RDATA, ST_WDATA, ST_STAT, ST_DROP} phase_type;
    phase_type                         phase_reg;
    logic [4:0]                        bitcnt_reg;
    logic [7:0]                        shin_reg;
    logic [7:0]                        shout_reg;
    logic [7:0]                        op_reg;
    logic [15:0]                       addr_reg;
    logic                              cs_d_reg;
    logic                              wel_reg;
    logic                              wip_reg;
    logic [$clog2(eeprom_ecc_pkg::WRITE_CYCLES)-1:0] wcnt_reg;
    logic                              pend_reg;
    logic [7:0]                        wbyte_reg;
    logic                              miso_reg;
    logic                              oe_reg;
    logic                              corr_reg;

    wire [7:0]  byte_in  = {shin_reg[6:0], mosi_s};
    wire        byte_end = sck_rise && bitcnt_reg == 5'd7;
    // address of the byte being handled: new address while it arrives, next byte in a read
    wire [15:0] addr_now = (phase_reg == ST_ADDR)  ? {addr_reg[7:0], byte_in} :
                           (phase_reg == ST_RDATA) ? addr_reg + 16'd1 : addr_reg;
    wire [11:0] grp      = addr_now[13:2];
    // (R10) correct single bit error of the addressed group
    wire [31:0] raw      = data_mem[grp];
    wire [5:0]  syn      = ham(raw) ^ chk_mem[grp];
    wire [5:0]  flip     = bit_of(syn);
    wire [31:0] fixed    = (flip[5] ? 32'h0 : (32'h1 << flip[4:0])) ^ raw;
    wire [7:0]  rd_byte  = fixed[8*addr_now[1:0] +: 8];
    // group word with the new byte merged over the corrected old content
    wire [31:0] merged   = (fixed & ~(32'hff << 8*addr_reg[1:0]))
                           | ({24'h0, byte_in} << 8*addr_reg[1:0]);
    wire        protect  = nv_reg.block_protect_hi | nv_reg.block_protect_lo;
    wire [7:0]  stat     = {nv_reg.status_write_disable_bit, 3'h0, nv_reg.block_protect_hi,
                            nv_reg.block_protect_lo, wel_reg, wip_reg};
    wire        cs_rise  = cs_n_s & ~cs_d_reg;

    // (R16) volatile protocol and status state under asynchronous reset
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            // (R2) standby, deselected
            phase_reg  <= ST_CMD;
            bitcnt_reg <= 5'd0;
            shin_reg   <= 8'h00;
            shout_reg  <= 8'h00;
            op_reg     <= 8'h00;
            addr_reg   <= 16'h0000;
            cs_d_reg   <= 1'b1;
            // (R3) latch cleared
            wel_reg    <= 1'b0;
            // (R4) no write running
            wip_reg    <= 1'b0;
            wcnt_reg   <= '0;
            pend_reg   <= 1'b0;
            wbyte_reg  <= 8'h00;
            miso_reg   <= 1'b0;
            oe_reg     <= 1'b0;
            corr_reg   <= 1'b0;
        end else begin
            cs_d_reg <= cs_n_s;
            corr_reg <= 1'b0;
            // (R8) release output when deselected
            oe_reg   <= ~cs_n_s & (phase_reg == ST_RDATA || phase_reg == ST_STAT);
            if (wip_reg) begin
                wcnt_reg <= wcnt_reg + 1'b1;
                if (&wcnt_reg) wip_reg <= 1'b0;
            end
            if (cs_n_s) begin
                phase_reg  <= ST_CMD;
                bitcnt_reg <= 5'd0;
                // (R11) write cycle starts on deselect at byte boundary
                if (cs_rise && pend_reg && bitcnt_reg == 5'd0) begin
                    wip_reg  <= 1'b1;
                    wcnt_reg <= '0;
                    wel_reg  <= 1'b0;
                end
                pend_reg <= 1'b0;
            end else if (sck_fall) begin
                miso_reg  <= shout_reg[7];
                shout_reg <= {shout_reg[6:0], 1'b0};
            end else if (sck_rise) begin
                shin_reg   <= byte_in;
                bitcnt_reg <= byte_end ? 5'd0 : bitcnt_reg + 5'd1;
                if (byte_end) begin
                    case (phase_reg)
                        ST_CMD: begin
                            op_reg <= byte_in;
                            if (wip_reg && byte_in != eeprom_ecc_pkg::OP_RDSR)
                                phase_reg <= ST_DROP;
                            else if (byte_in == eeprom_ecc_pkg::OP_WREN) begin
                                wel_reg <= 1'b1;
                                phase_reg <= ST_DROP;
                            end else if (byte_in == eeprom_ecc_pkg::OP_WRDI) begin
                                wel_reg <= 1'b0;
                                phase_reg <= ST_DROP;
                            end else if (byte_in == eeprom_ecc_pkg::OP_RDSR) begin
                                shout_reg <= stat;
                                phase_reg <= ST_STAT;
                            end else if (byte_in == eeprom_ecc_pkg::OP_READ ||
                                         byte_in == eeprom_ecc_pkg::OP_WRITE)
                                phase_reg <= ST_ADDR;
                            else
                                phase_reg <= ST_DROP;
                        end
                        ST_ADDR: begin
                            addr_reg <= {addr_reg[7:0], byte_in};
                            if (bitcnt_reg == 5'd7 && op_reg[7]) begin
                                op_reg[7] <= 1'b0;
                                if (op_reg[6:0] == eeprom_ecc_pkg::OP_READ[6:0])
                                    phase_reg <= ST_RDATA;
                                else
                                    phase_reg <= ST_WDATA;
                            end else
                                op_reg[7] <= 1'b1;
                        end
                        ST_WDATA: begin
                            // (R11) read-modify-write of the whole group
                            if (wel_reg && !protect) begin
                                data_mem[grp] <= merged;
                                chk_mem[grp]  <= ham(merged);
                                pend_reg <= 1'b1;
                            end
                            addr_reg[5:0] <= addr_reg[5:0] + 6'd1;
                        end
                        ST_STAT:  shout_reg <= stat;
                        default:  phase_reg <= phase_reg;
                    endcase
                end
                // (R12) read data loads on the same edge as without correction
                if (phase_reg == ST_ADDR && byte_end && op_reg[7] &&
                    op_reg[6:0] == eeprom_ecc_pkg::OP_READ[6:0]) begin
                    shout_reg <= rd_byte;
                end else if (phase_reg == ST_RDATA && byte_end) begin
                    // (R10) next byte also passes through correction
                    shout_reg <= rd_byte;
                    addr_reg  <= addr_reg + 16'd1;
                    corr_reg  <= ~flip[5];
                end
            end
        end
    end

    // (R5) non-volatile status bits are never touched by reset
    assign o_nv_status          = nv_reg;
    assign o_miso               = miso_reg;
    assign o_miso_oe            = oe_reg;
    assign o_write_in_progress  = wip_reg;
    assign o_write_enable_latch = wel_reg;
    assign o_ecc_corrected      = corr_reg;

    // (R8) output released while deselected
    a_miso_released: assert property (@(posedge i_sys_clk) disable iff (!i_nrst) // (R8)
        $past(cs_n_s) |-> !o_miso_oe)
        else $error("data output driven while deselected");
    // (R1) no latch set without supply
    a_no_cmd_low: assert property (@(posedge i_sys_clk) disable iff (!i_nrst) // (R1)
        !i_supply_ok && !wel_reg |=> !wel_reg)
        else $error("instruction accepted below threshold");
    // (R3) latch cleared once write cycle launched
    a_wel_after_wr: assert property (@(posedge i_sys_clk) disable iff (!i_nrst) // (R3)
        $rose(wip_reg) |-> !wel_reg)
        else $error("write enable latch survived write start");
    // (R4) write cycle bounded
    a_wip_bounded: assert property (@(posedge i_sys_clk) disable iff (!i_nrst) // (R4)
        $rose(wip_reg) |-> ##[1:64] !wip_reg)
        else $error("write in progress stuck");
    // (R10) correction flag only during reads
    a_corr_in_read: assert property (@(posedge i_sys_clk) disable iff (!i_nrst) // (R10)
        o_ecc_corrected |-> $past(phase_reg) == ST_RDATA)
        else $error("correction outside read");
    // (R2) deselected idle phase
    a_idle_deselect: assert property (@(posedge i_sys_clk) disable iff (!i_nrst) // (R2)
        cs_n_s |=> phase_reg == ST_CMD)
        else $error("not idle while deselected");
    // (R11) write only with latch set
    a_write_needs_wel: assert property (@(posedge i_sys_clk) disable iff (!i_nrst) // (R11)
        $rose(pend_reg) |-> $past(wel_reg))
        else $error("group write without latch");
    // (R12) output stable between falling clock edges
    a_miso_timing: assert property (@(posedge i_sys_clk) disable iff (!i_nrst) // (R12)
        !$past(sck_fall) && !$past(cs_n_s) |-> $stable(o_miso))
        else $error("data output moved off clock edge");
endmodule : eeprom_ecc_core

// ---- eeprom_ecc_core_tb.sv ----
// Purpose: self-checking bench for the eeprom power-on reset and ecc group core
// Assumes: memory model in the bench mirrors every accepted byte write
// Notes:   random addresses and data from a fixed seed, top group and the group at 0x0004 as corners
`timescale 1ns/1ns
module eeprom_ecc_core_tb;
    logic                          i_sys_clk;
    logic                          i_nrst;
    logic                          i_supply_ok;
    logic                          i_hold_n;
    eeprom_ecc_pkg::spi_in_type    spi;
    logic                          o_miso;
    logic                          o_miso_oe;
    logic                          o_write_in_progress;
    logic                          o_write_enable_latch;
    logic                          o_ecc_corrected;
    eeprom_ecc_pkg::nv_status_type o_nv_status;
    eeprom_ecc_pkg::nv_status_type nv_keep;
    int                            failures;
    int                            num_checks;
    int                            seed;
    logic [7:0]                    mem [int];
    logic [7:0]                    rx;
    logic [13:0]                   addr;

    eeprom_ecc_core i_eeprom_ecc_core (
        .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_supply_ok(i_supply_ok), .i_spi(spi),
        .i_hold_n(i_hold_n), .o_miso(o_miso), .o_miso_oe(o_miso_oe),
        .o_write_in_progress(o_write_in_progress), .o_write_enable_latch(o_write_enable_latch),
        .o_nv_status(o_nv_status), .o_ecc_corrected(o_ecc_corrected));
    spi_master_model i_spi_master_model (.o_spi(spi), .i_miso(o_miso), .i_miso_oe(o_miso_oe));

    // system clock
    initial begin
        i_sys_clk = 1'b0;
        forever #10 i_sys_clk = ~i_sys_clk;
    end

    // compare helpers and closing report
    task automatic chk_flag(input string what, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %b seen %b", what, exp, got);
        end
    endtask : chk_flag
    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk_byte
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : wrap_up

    function automatic logic [7:0] exp_byte(input logic [13:0] a);
        return mem.exists(int'(a)) ? mem[int'(a)] : eeprom_ecc_pkg::ERASED_BYTE;
    endfunction : exp_byte

    // spi transactions
    task automatic op(input logic [7:0] code);
        i_spi_master_model.frame_begin();
        i_spi_master_model.xfer(code, rx);
        i_spi_master_model.frame_end();
    endtask : op
    task automatic send_write(input logic [13:0] a, input logic [7:0] d);
        op(eeprom_ecc_pkg::OP_WREN);
        i_spi_master_model.frame_begin();
        i_spi_master_model.xfer(eeprom_ecc_pkg::OP_WRITE, rx);
        i_spi_master_model.xfer({2'b00, a[13:8]}, rx);
        i_spi_master_model.xfer(a[7:0], rx);
        i_spi_master_model.xfer(d, rx);
        i_spi_master_model.frame_end();
        mem[int'(a)] = d;
    endtask : send_write
    task automatic wait_idle();
        int n;
        n = 0;
        while (o_write_in_progress !== 1'b0 && n < 300) begin
            @(posedge i_sys_clk);
            n++;
        end
        if (n >= 300) begin
            failures++;
            wrap_up();
        end
    endtask : wait_idle
    task automatic read_check(input logic [13:0] a, input int cnt);
        i_spi_master_model.frame_begin();
        i_spi_master_model.xfer(eeprom_ecc_pkg::OP_READ, rx);
        i_spi_master_model.xfer({2'b00, a[13:8]}, rx);
        i_spi_master_model.xfer(a[7:0], rx);
        for (int i = 0; i < cnt; i++) begin
            i_spi_master_model.xfer(8'h00, rx);
            chk_byte("read byte", exp_byte(a + 14'(i)), rx);
            chk_flag("output enable in read", 1'b1, o_miso_oe);
            chk_flag("correction pulse", 1'b0, o_ecc_corrected);
        end
        i_spi_master_model.frame_end();
        chk_flag("output enable deselected", 1'b0, o_miso_oe);
    endtask : read_check

    // hang guard
    initial begin
        #1_500_000;
        failures++;
        wrap_up();
    end

    // main sequence
    initial begin
        seed        = 96;
        failures    = 0;
        num_checks  = 0;
        i_nrst      = 1'b0;
        i_supply_ok = 1'b1;
        i_hold_n    = 1'b1;
        repeat (16) @(posedge i_sys_clk);
        i_nrst <= 1'b1;
        repeat (2) @(posedge i_sys_clk);
        chk_flag("write enable latch", 1'b0, o_write_enable_latch);
        chk_flag("write in progress", 1'b0, o_write_in_progress);
        chk_flag("output enable", 1'b0, o_miso_oe);
        chk_byte("nv status", 8'h00, {5'h00, o_nv_status});
        $display("test power_up done");
        read_check(14'($random(seed)), 8);
        read_check(14'h3ffc, 4);
        $display("test factory_read done");
        @(posedge i_sys_clk) i_supply_ok <= 1'b0;
        op(eeprom_ecc_pkg::OP_WREN);
        chk_flag("latch with supply low", 1'b0, o_write_enable_latch);
        i_spi_master_model.frame_begin();
        i_spi_master_model.xfer(eeprom_ecc_pkg::OP_RDSR, rx);
        i_spi_master_model.xfer(8'h00, rx);
        chk_flag("output enable supply low", 1'b0, o_miso_oe);
        i_spi_master_model.frame_end();
        @(posedge i_sys_clk) i_supply_ok <= 1'b1;
        $display("test supply_low done");
        op(eeprom_ecc_pkg::OP_WREN);
        chk_flag("latch after enable", 1'b1, o_write_enable_latch);
        i_spi_master_model.frame_begin();
        i_spi_master_model.xfer(eeprom_ecc_pkg::OP_RDSR, rx);
        i_spi_master_model.xfer(8'h00, rx);
        i_spi_master_model.frame_end();
        chk_byte("status byte", 8'h01 << eeprom_ecc_pkg::WEL_BIT, rx & 8'h8f);
        op(eeprom_ecc_pkg::OP_WRDI);
        $display("test status done");
        for (int k = 0; k < 8; k++) begin
            addr = (k == 0) ? 14'h3fff : (k == 1) ? 14'h0004 : 14'($random(seed));
            send_write(addr, 8'($random(seed)));
            wait_idle();
            read_check({addr[13:2], 2'b00}, 4);
        end
        $display("test group_write done");
        send_write(14'h0102, 8'($random(seed)));
        chk_flag("busy after write", 1'b1, o_write_in_progress);
        nv_keep = o_nv_status;
        @(posedge i_sys_clk) i_nrst <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        chk_flag("busy in reset", 1'b0, o_write_in_progress);
        i_nrst <= 1'b1;
        repeat (2) @(posedge i_sys_clk);
        chk_flag("busy after reset", 1'b0, o_write_in_progress);
        chk_flag("latch after reset", 1'b0, o_write_enable_latch);
        chk_byte("nv status kept", {5'h00, nv_keep}, {5'h00, o_nv_status});
        read_check(14'h0100, 4);
        $display("test reset_in_write done");
        wrap_up();
    end
endmodule : eeprom_ecc_core_tb

// ---- eeprom_ecc_pkg.sv ----
// Purpose: shared constants and types for the serial eeprom por/ecc core
// Assumes: one system clock, spi pins sampled through two flip-flops
// Notes:   group code is a hamming single-error-correcting 6-bit check over 32 data bits
package eeprom_ecc_pkg;
    localparam int ADDR_W      = 14;            // 16 kbyte array
    localparam int GROUP_BYTES = 4;             // bytes sharing one check word
    localparam int NUM_GROUPS  = 4096;
    localparam int CHK_W       = 6;             // hamming check bits for 32 data bits
    localparam int ID_BYTES    = 64;            // identification page
    localparam int ID_CODE_LEN = 3;
    localparam logic [7:0]  ERASED_BYTE  = 8'hff;
    localparam logic [23:0] ID_CODE      = 24'h5a_a5_3c; // arbitrary value
    localparam logic [7:0]  OP_WREN  = 8'h06;
    localparam logic [7:0]  OP_WRDI  = 8'h04;
    localparam logic [7:0]  OP_RDSR  = 8'h05;
    localparam logic [7:0]  OP_READ  = 8'h03;
    localparam logic [7:0]  OP_WRITE = 8'h02;
    localparam int WEL_BIT = 1;
    localparam int WIP_BIT = 0;
    localparam int BPL_BIT = 2;
    localparam int BPH_BIT = 3;
    localparam int SWD_BIT = 7;
    localparam int WRITE_CYCLES = 64;           // self-timed write length in clocks

    typedef struct packed {
        logic status_write_disable_bit;
        logic block_protect_hi;
        logic block_protect_lo;
    } nv_status_type;

    typedef struct packed {
        logic cs_n;
        logic sck;
        logic mosi;
    } spi_in_type;
endpackage : eeprom_ecc_pkg

// ---- spi_master_model.sv ----
// Purpose: behavioural spi bus master for the eeprom core bench
// Assumes: mode 0, sck idle low, 160 ns link period unrelated in phase to i_sys_clk
// Notes:   a released data line reads as the inverse of the last driven bit
`timescale 1ns/1ns
module spi_master_model (
    // pins towards the device
    output eeprom_ecc_pkg::spi_in_type o_spi,
    // serial data back from the device
    input  wire logic                  i_miso,
    input  wire logic                  i_miso_oe
);
    logic      last_bit;
    wire logic line_q = i_miso_oe ? i_miso : ~last_bit; // floating line never repeats

    // idle bus: deselected, clock parked low
    initial begin
        o_spi    = '{cs_n: 1'b1, sck: 1'b0, mosi: 1'b0};
        last_bit = 1'b0;
    end

    task automatic frame_begin();
        #37 o_spi.cs_n = 1'b0;
        #80;
    endtask : frame_begin

    // shift one byte msb first, sample late in the high phase
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            o_spi.mosi = tx[i];
            #80 o_spi.sck = 1'b1;
            #60 rx[i] = line_q;
            if (i_miso_oe) last_bit = i_miso;
            #20 o_spi.sck = 1'b0;
        end
    endtask : xfer

    task automatic frame_end();
        #80 o_spi.cs_n = 1'b1;
        o_spi.mosi = ~o_spi.mosi;    // unused data line keeps moving
        #160;
    endtask : frame_end
endmodule : spi_master_model
